// ### apt_defs.vh
// Constants for the converter pair trigger control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, word aligned.
`ifndef APT_DEFS_VH
`define APT_DEFS_VH

// ==========================================
// Register byte offsets
`define APT_CTRL1_OFS 4'h0
`define APT_CTRL2_OFS 4'h4
`define APT_STAT_OFS 4'h8

// ==========================================
// Control register 1 fields
`define APT_P3SEL_MSB 12
`define APT_P3SEL_LSB 8
`define APT_P2IRQEN_BIT 7
`define APT_P2PEND_BIT 6
`define APT_P2SWTRG_BIT 5

// ==========================================
// Control register 2 fields
`define APT_P3SWTRG_BIT 5
`define APT_P2SEL_MSB 4
`define APT_P2SEL_LSB 0

// ==========================================
// Status register fields
`define APT_ST_P2PEND_BIT 0
`define APT_ST_P3PEND_BIT 1
`define APT_ST_BUSY_BIT 2
`define APT_ST_INFLIGHT_BIT 3

// ==========================================
// Reset values
`define APT_SEL_RST 5'h00
`define APT_BIT_RST 1'b0

// ==========================================
// Trigger selector codes
`define APT_TRG_NONE 5'h00
`define APT_TRG_SW_IND 5'h01
`define APT_TRG_SW_GLB 5'h02
`define APT_TRG_SPECIAL 5'h03
`define APT_TRG_PRI_FIRST 5'h04
`define APT_TRG_PRI_LAST 5'h07
`define APT_TRG_TMR1 5'h0c
`define APT_TRG_SEC_FIRST 5'h0e
`define APT_TRG_SEC_LAST 5'h11
`define APT_TRG_CL_FIRST 5'h17
`define APT_TRG_CL_LAST 5'h1a
`define APT_TRG_TMR2 5'h1f

// ==========================================
// Pair numbers on the engine port
`define APT_PAIR2 2'h2
`define APT_PAIR3 2'h3

`endif

// ### apt_pair_trigger_control.v
// Trigger selection, pending state and request arbitration for two
// converter input pairs, with an Avalon-MM register slave.
// Assumes all trigger sources and the conversion engine run on clock_i
// and present triggers as one-cycle pulses.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "apt_defs.vh"

module apt_pair_trigger_control (
    // Clock and reset
    input wire clock_i,
    input wire sys_rst_i,
    // Avalon-MM register slave
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Trigger sources
    input wire global_sw_trig_i,
    input wire special_event_trig_i,
    input wire [3:0] pwm_primary_trig_i,
    input wire [3:0] pwm_secondary_trig_i,
    input wire [3:0] pwm_current_limit_trig_i,
    input wire timer1_period_i,
    input wire timer2_period_i,
    // Conversion engine
    input wire conv_busy_i,
    input wire conv_done_i,
    output reg conv_start_o,
    output reg [1:0] conv_pair_o,
    // Interrupt request to the interrupt controller
    output reg pair2_irq_o
);

// ==========================================
// Arbiter states
localparam ST_IDLE = 1'b0;
localparam ST_BUSY = 1'b1;

// ==========================================
// Trigger decode, shared by both pairs
function trig_hit;
    input [4:0] sel;
    input sw_bit;
    input gsw;
    input sev;
    input [3:0] pri;
    input [3:0] sec;
    input [3:0] cl;
    input t1;
    input t2;
    begin
        trig_hit = 1'b0;
        case (sel)
            `APT_TRG_NONE: trig_hit = 1'b0;
            `APT_TRG_SW_IND: trig_hit = sw_bit;
            `APT_TRG_SW_GLB: trig_hit = sw_bit | gsw;
            `APT_TRG_SPECIAL: trig_hit = sev;
            5'h04: trig_hit = pri[0];
            5'h05: trig_hit = pri[1];
            5'h06: trig_hit = pri[2];
            `APT_TRG_PRI_LAST: trig_hit = pri[3];
            `APT_TRG_TMR1: trig_hit = t1;
            `APT_TRG_SEC_FIRST: trig_hit = sec[0];
            5'h0f: trig_hit = sec[1];
            5'h10: trig_hit = sec[2];
            `APT_TRG_SEC_LAST: trig_hit = sec[3];
            `APT_TRG_CL_FIRST: trig_hit = cl[0];
            5'h18: trig_hit = cl[1];
            5'h19: trig_hit = cl[2];
            `APT_TRG_CL_LAST: trig_hit = cl[3];
            `APT_TRG_TMR2: trig_hit = t2;
            // Reserved codes start nothing
            default: trig_hit = 1'b0;
        endcase
    end
endfunction

// ==========================================
// State
reg [4:0] p3_sel;
reg [4:0] p2_sel;
reg p2_irq_en;
reg p2_swtrg;
reg p3_swtrg;
reg p2_pend;
reg p3_pend;
reg state;
reg inflight;

// ==========================================
// Bus decode
wire bus_req;
wire acc_done;
wire wr_acc;
wire wr_ctrl1;
wire wr_ctrl2;
reg [31:0] next_rdata;

assign bus_req = avs_read_i | avs_write_i;
// Access completes at the edge where waitrequest is seen low
assign acc_done = bus_req & ~avs_waitrequest_o;
assign wr_acc = avs_write_i & ~avs_waitrequest_o;
assign wr_ctrl1 = wr_acc & (avs_address_i == `APT_CTRL1_OFS);
assign wr_ctrl2 = wr_acc & (avs_address_i == `APT_CTRL2_OFS);

always @* begin
    next_rdata = 32'h0000_0000;
    case (avs_address_i)
        `APT_CTRL1_OFS: begin
            next_rdata[`APT_P3SEL_MSB:`APT_P3SEL_LSB] = p3_sel;
            next_rdata[`APT_P2IRQEN_BIT] = p2_irq_en;
            next_rdata[`APT_P2PEND_BIT] = p2_pend;
            next_rdata[`APT_P2SWTRG_BIT] = p2_swtrg;
        end
        `APT_CTRL2_OFS: begin
            next_rdata[`APT_P3SWTRG_BIT] = p3_swtrg;
            next_rdata[`APT_P2SEL_MSB:`APT_P2SEL_LSB] = p2_sel;
        end
        `APT_STAT_OFS: begin
            next_rdata[`APT_ST_P2PEND_BIT] = p2_pend;
            next_rdata[`APT_ST_P3PEND_BIT] = p3_pend;
            next_rdata[`APT_ST_BUSY_BIT] = state;
            next_rdata[`APT_ST_INFLIGHT_BIT] = inflight;
        end
        // Unmapped words read as zero
        default: next_rdata = 32'h0000_0000;
    endcase
end

// ==========================================
// Trigger evaluation and completion
// Triggers count as one-cycle pulses; a held level retriggers
wire p2_hit;
wire p3_hit;
wire done_p2;
wire done_p3;
wire start_now;

assign p2_hit = trig_hit(p2_sel, p2_swtrg, global_sw_trig_i,
    special_event_trig_i, pwm_primary_trig_i, pwm_secondary_trig_i,
    pwm_current_limit_trig_i, timer1_period_i, timer2_period_i);
assign p3_hit = trig_hit(p3_sel, p3_swtrg, global_sw_trig_i,
    special_event_trig_i, pwm_primary_trig_i, pwm_secondary_trig_i,
    pwm_current_limit_trig_i, timer1_period_i, timer2_period_i);

assign done_p2 = conv_done_i & (state == ST_BUSY) & ~inflight;
assign done_p3 = conv_done_i & (state == ST_BUSY) & inflight;
// Held while the shared engine is busy elsewhere
assign start_now = (state == ST_IDLE) & ~conv_busy_i &
    (p2_pend | p3_pend);

// ==========================================
// Bus handshake: one wait cycle, then the answer
always @(posedge clock_i) begin
    if (sys_rst_i) begin
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o <= 32'h0000_0000;
    end else begin
        if (bus_req & avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= next_rdata;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
        // Read data drops to zero once answered
        if (acc_done) begin
            avs_readdata_o <= 32'h0000_0000;
        end
    end
end

// ==========================================
// Software-written fields
// The pending bit is status only; writes skip it
always @(posedge clock_i) begin
    if (sys_rst_i) begin
        p3_sel <= `APT_SEL_RST;
        p2_sel <= `APT_SEL_RST;
        p2_irq_en <= `APT_BIT_RST;
    end else begin
        if (wr_ctrl1 & avs_byteenable_i[1]) begin
            p3_sel <= avs_writedata_i[`APT_P3SEL_MSB:`APT_P3SEL_LSB];
        end
        if (wr_ctrl1 & avs_byteenable_i[0]) begin
            p2_irq_en <= avs_writedata_i[`APT_P2IRQEN_BIT];
        end
        if (wr_ctrl2 & avs_byteenable_i[0]) begin
            p2_sel <= avs_writedata_i[`APT_P2SEL_MSB:`APT_P2SEL_LSB];
        end
    end
end

// ==========================================
// Software trigger bits; a write in the clearing cycle wins
// A bit set under code 0 waits for a software code; a hit of any other selected source clears it
always @(posedge clock_i) begin
    if (sys_rst_i) begin
        p2_swtrg <= `APT_BIT_RST;
        p3_swtrg <= `APT_BIT_RST;
    end else begin
        if (wr_ctrl1 & avs_byteenable_i[0]) begin
            p2_swtrg <= avs_writedata_i[`APT_P2SWTRG_BIT];
        end else if (p2_hit) begin
            p2_swtrg <= 1'b0;
        end
        if (wr_ctrl2 & avs_byteenable_i[0]) begin
            p3_swtrg <= avs_writedata_i[`APT_P3SWTRG_BIT];
        end else if (p3_hit) begin
            p3_swtrg <= 1'b0;
        end
    end
end

// ==========================================
// Pending flags; a new trigger beats the completion clear
// A trigger for a pair already pending is absorbed
always @(posedge clock_i) begin
    if (sys_rst_i) begin
        p2_pend <= `APT_BIT_RST;
        p3_pend <= `APT_BIT_RST;
    end else begin
        if (p2_hit) begin
            p2_pend <= 1'b1;
        end else if (done_p2) begin
            p2_pend <= 1'b0;
        end
        if (p3_hit) begin
            p3_pend <= 1'b1;
        end else if (done_p3) begin
            p3_pend <= 1'b0;
        end
    end
end

// ==========================================
// Arbitration choice, pair2 ahead of pair3
reg next_inflight;
reg [1:0] next_pair;

always @* begin
    next_inflight = 1'b0;
    next_pair = `APT_PAIR2;
    if (~p2_pend & p3_pend) begin
        next_inflight = 1'b1;
        next_pair = `APT_PAIR3;
    end
end

// ==========================================
// Arbiter toward the shared conversion engine
always @(posedge clock_i) begin
    if (sys_rst_i) begin
        state <= ST_IDLE;
        inflight <= 1'b0;
        conv_start_o <= 1'b0;
        conv_pair_o <= `APT_PAIR2;
        pair2_irq_o <= 1'b0;
    end else begin
        conv_start_o <= 1'b0;
        pair2_irq_o <= done_p2 & p2_irq_en;
        case (state)
            ST_IDLE: begin
                if (start_now) begin
                    state <= ST_BUSY;
                    conv_start_o <= 1'b1;
                    inflight <= next_inflight;
                    conv_pair_o <= next_pair;
                end
            end
            ST_BUSY: begin
                // Stays here until the engine reports completion
                if (conv_done_i) begin
                    state <= ST_IDLE;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

endmodule
`default_nettype wire

// ### apt_engine_model.sv
// Behavioural conversion engine facing the pair trigger block.
// Assumes clock_i is shared; the bench sets latency and foreign load.
`timescale 1ns/1ps
`default_nettype none
module apt_engine_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // From the block and the bench
    input wire logic start_i,
    input wire logic other_i,
    input wire logic [7:0] lat_i,
    // To the block
    output logic busy_o,
    output logic done_o
);
    logic run;
    logic [7:0] cnt;
    // Busy means foreign work only; own work ends with done
    assign busy_o = other_i;
    always @(posedge clock_i) begin
        done_o <= 1'b0;
        if (sys_rst_i) begin
            run <= 1'b0;
        end else if (start_i) begin
            run <= 1'b1;
            cnt <= lat_i;
        end else if (run && cnt == 8'h00) begin
            run <= 1'b0;
            done_o <= 1'b1;
        end else begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### apt_pair_trigger_control_monitor.sv
// Port checker for the pair trigger control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module apt_monitor (
    // Clock, reset and bus
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Engine and interrupt
    input wire logic conv_busy_i,
    input wire logic conv_done_i,
    input wire logic conv_start_o,
    input wire logic [1:0] conv_pair_o,
    input wire logic pair2_irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // ==========================================
    // Register bus
    wait_once_a: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer too long");
    rdata_idle_a: assert property (avs_waitrequest_o |->
        avs_readdata_o == 32'h0) else $error("stray read data");
    // ==========================================
    // Engine requests
    start_gap_a: assert property (conv_start_o |=> !conv_start_o [*2])
        else $error("start too soon");
    start_free_a: assert property (conv_start_o |-> !$past(conv_busy_i))
        else $error("start while busy");
    pair_hold_a: assert property (!conv_start_o |-> $stable(conv_pair_o))
        else $error("pair moved");
    done_gap_a: assert property (conv_done_i |=> !conv_start_o)
        else $error("no idle after done");
    irq_cause_a: assert property (pair2_irq_o |-> $past(conv_done_i) &&
        conv_pair_o == 2'h2) else $error("irq without done");
endmodule
bind apt_pair_trigger_control apt_monitor apt_monitor_i (.clock_i,
    .sys_rst_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
    .avs_waitrequest_o, .conv_busy_i, .conv_done_i, .conv_start_o,
    .conv_pair_o, .pair2_irq_o);
`default_nettype wire

// ### test_apt_pair_trigger_control.sv
// Self-checking bench for the pair trigger control block.
// Assumes the engine model and the checker bind are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_apt_pair_trigger_control;
    logic clock_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic conv_busy_i, conv_done_i, conv_start_o, pair2_irq_o, other_busy;
    logic [1:0] conv_pair_o;
    logic [3:0] avs_address_i;
    logic [7:0] lat;
    logic [15:0] trig;
    logic [31:0] avs_writedata_i, avs_readdata_o, rq;
    logic [1:0] exp_q[$];
    int bad_count, n_compared, cyc, n_irq, exp_irq, seed, s, c;

    apt_pair_trigger_control apt_pair_trigger_control_i (.clock_i,
        .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
        .avs_waitrequest_o, .global_sw_trig_i(trig[0]),
        .special_event_trig_i(trig[1]), .pwm_primary_trig_i(trig[5:2]),
        .pwm_secondary_trig_i(trig[9:6]),
        .pwm_current_limit_trig_i(trig[13:10]), .timer1_period_i(trig[14]),
        .timer2_period_i(trig[15]), .conv_busy_i, .conv_done_i,
        .conv_start_o, .conv_pair_o, .pair2_irq_o);
    apt_engine_model apt_engine_model_i (.clock_i, .sys_rst_i,
        .start_i(conv_start_o), .other_i(other_busy), .lat_i(lat),
        .busy_o(conv_busy_i), .done_o(conv_done_i));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task tally_and_finish;
        $display("mismatches %0d compares %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One access; request held until waitrequest is seen low
    task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        rq = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        acc(1'b0, a, 32'h0);
        chk(rq & m, e);
    endtask

    // Poll status until neither pair is pending
    task settle;
        int k;
        k = 0;
        do begin
            acc(1'b0, 4'h8, 32'h0);
            k++;
        end while (rq[1:0] !== 2'b00 && k < 60);
        chk({30'h0, rq[1:0]}, 32'h0);
    endtask

    // Trigger line index per selector code, -1 for none
    function int src_of(input int k);
        case (k)
            2, 3, 4, 5, 6, 7: return k - 2;
            14, 15, 16, 17: return k - 8;
            23, 24, 25, 26: return k - 13;
            12: return 14;
            31: return 15;
            default: return -1;
        endcase
    endfunction

    always @(posedge clock_i) begin
        cyc++;
        if (pair2_irq_o === 1'b1)
            n_irq++;
        if (conv_start_o === 1'b1 && exp_q.size() == 0)
            chk(32'h1, 32'h0);
        else if (conv_start_o === 1'b1)
            chk({30'h0, conv_pair_o}, {30'h0, exp_q.pop_front()});
        if (cyc > 30000) begin
            bad_count++;
            tally_and_finish;
        end
    end

    initial begin
        seed = 31140;
        sys_rst_i = 1'b1;
        {avs_read_i, avs_write_i, other_busy} = 3'h0;
        avs_address_i = 4'h0;
        avs_writedata_i = 32'h0;
        trig = 16'h0;
        lat = 8'h04;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(4'h0, 32'h0, 32'hffffffff);
        rd(4'h8, 32'h0, 32'hffffffff);
        rd(4'hc, 32'h0, 32'hffffffff);
        for (c = 0; c < 32; c++) begin
            lat <= 8'($random(seed) & 32'hf);
            acc(1'b1, 4'h4, {27'h0, c[4:0]});
            acc(1'b1, 4'h0, {19'h0, c[4:0], 8'h00});
            s = src_of(c);
            if (s < 0 || $random(seed) % 2 != 0)
                s = {$random(seed)} % 16;
            if (s == src_of(c)) begin
                exp_q.push_back(2'h2);
                exp_q.push_back(2'h3);
            end
            trig <= 16'h1 << s;
            @(posedge clock_i);
            trig <= 16'h0;
            settle;
        end
        // Hold both pairs behind foreign work, then release
        acc(1'b1, 4'h4, 32'h2);
        other_busy <= 1'b1;
        acc(1'b1, 4'h0, 32'h1a0);
        rd(4'h0, 32'h1c0, 32'hffffffff);
        acc(1'b1, 4'h4, 32'h22);
        rd(4'h8, 32'h3, 32'h3);
        exp_q = '{2'h2, 2'h3};
        exp_irq = 1;
        other_busy <= 1'b0;
        settle;
        acc(1'b1, 4'h0, 32'h20);
        exp_q.push_back(2'h2);
        settle;
        acc(1'b1, 4'h4, 32'h0);
        acc(1'b1, 4'h0, 32'h20);
        rd(4'h0, 32'h0, 32'h40);
        acc(1'b1, 4'h0, 32'h0);
        chk(exp_q.size(), 32'h0);
        chk(n_irq, exp_irq);
        tally_and_finish;
    end
endmodule
`default_nettype wire
